// ---- sbtc_pkg.sv ----
// Purpose: shared constants and types for the sixteen-bit timer/counter
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word
// Notes:   register offsets are byte addresses

package sbtc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_FLAG_REG    = 8'h08;
  localparam logic [7:0] ADDR_ENABLE_REG  = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL     = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FLAG_BIT         = 0;
  localparam int         STATUS_ARMED_BIT = 0;
  localparam int         STATUS_FORCE_BIT = 1;
  localparam int         STATUS_TBASE_BIT = 2;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;

  // ----------------------------------------------------------------
  // timing and widths
  // ----------------------------------------------------------------
  localparam int         PRESCALE_WIDTH   = 3;
  localparam int         SYNC_STAGES      = 3;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] input_prescale_select;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       count_source_select;
    logic       count_run;
  } sbtc_control_type;

  // time base offered to the capture/compare units
  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } sbtc_time_base_type;

endpackage

// ---- sbtc_timer.sv ----
// Purpose: sixteen-bit timer/counter with prescaler and AXI4-Lite registers
// Assumes: aclk is the instruction clock (Fosc/4); pins are asynchronous
// Notes:   one clock domain; pin edges are found after a three-stage sampler
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps

module sbtc_timer
  import sbtc_pkg::*;
(
  // clock, reset, freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // processor state
  input  wire logic        sleep,
  // pins
  input  wire logic        ext_count_pin,
  input  wire logic        osc_input_pin,
  // capture/compare reset events
  input  wire logic        ccp1_reset_event,
  input  wire logic        ccp2_reset_event,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // results
  output logic             irq_request,
  output logic             wake_request,
  output sbtc_time_base_type time_base,
  output logic             crystal_osc_power_on,
  output logic             osc_pins_force_input
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  sbtc_control_type            control_q;
  logic [15:0]                 count_q;
  logic                        flag_q;
  logic                        irq_enable_q;
  logic [SYNC_STAGES-1:0]      pin_sync_q;
  logic                        pin_level_q;
  logic                        armed_q;
  logic [PRESCALE_WIDTH-1:0]   prescale_q;
  logic                        aw_have_q;
  logic                        w_have_q;
  logic [7:0]                  aw_addr_q;
  logic [7:0]                  w_data_q;
  logic                        w_lane0_q;

  // ----------------------------------------------------------------
  // pin sampling and edge finding
  // ----------------------------------------------------------------
  logic pin_select;
  logic pin_agree;
  logic pin_rise;
  logic pin_fall;
  assign pin_select = control_q.crystal_osc_enable ? osc_input_pin : ext_count_pin;
  assign pin_agree  = pin_sync_q[1] == pin_sync_q[2];
  assign pin_rise   = pin_agree && pin_sync_q[2] && !pin_level_q;
  assign pin_fall   = pin_agree && !pin_sync_q[2] && pin_level_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_q  <= '0;
      pin_level_q <= 1'b0;
    end else if (clk_en) begin
      pin_sync_q <= {pin_sync_q[1:0], pin_select};
      if (pin_agree) begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic write_go;
  logic write_low;
  logic write_high;
  logic count_write;
  assign write_go    = aw_have_q && w_have_q && !s_axi_bvalid && w_lane0_q;
  assign write_low   = write_go && aw_addr_q == ADDR_COUNT_LOW;
  assign write_high  = write_go && aw_addr_q == ADDR_COUNT_HIGH;
  assign count_write = write_low || write_high;

  // ----------------------------------------------------------------
  // counting path
  // ----------------------------------------------------------------
  logic counter_mode;
  logic sync_mode;
  logic source_tick;
  logic prescale_out;
  logic main_stalled;
  logic count_inc;
  logic ccp_reset;
  logic [2:0] prescale_mask;
  assign counter_mode = control_q.count_source_select;
  assign sync_mode    = counter_mode && !control_q.sync_bypass;
  // timer mode ticks every instruction cycle outside sleep; counter mode waits for arming
  assign source_tick  = control_q.count_run &&
                        (counter_mode ? (pin_rise && armed_q) : !sleep);
  always_comb begin
    unique case (control_q.input_prescale_select)
      2'b00:   prescale_mask = 3'h0;
      2'b01:   prescale_mask = 3'h1;
      2'b10:   prescale_mask = 3'h3;
      2'b11:   prescale_mask = 3'h7;
    endcase
  end
  assign prescale_out = source_tick && ((prescale_q & prescale_mask) == prescale_mask);
  // the synchronizer stage is shut off in sleep, the prescaler is not
  assign main_stalled = sleep && sync_mode;
  assign count_inc    = prescale_out && !main_stalled;
  assign ccp_reset    = ccp1_reset_event || ccp2_reset_event;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (!control_q.count_run || !counter_mode) begin
        armed_q <= 1'b0;
      end else if (pin_fall) begin
        armed_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_q <= '0;
    end else if (clk_en) begin
      if (count_write) begin
        prescale_q <= '0;
      end else if (source_tick) begin
        prescale_q <= prescale_out ? '0 : prescale_q + 3'h1;
      end
    end
  end

  // the count keeps its value through aresetn; a compare reset event clears it unless a count byte write comes in the same cycle
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (write_low) begin
        count_q[7:0] <= w_data_q;
      end else if (write_high) begin
        count_q[15:8] <= w_data_q;
      end else if (ccp_reset) begin
        count_q <= COUNT_ZERO;
      end else if (count_inc) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // overflow flag and enables
  // ----------------------------------------------------------------
  logic wrap;
  assign wrap = count_inc && !count_write && !ccp_reset && count_q == COUNT_MAX;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (wrap) begin
        flag_q <= 1'b1;
      end else if (write_go && aw_addr_q == ADDR_FLAG_REG) begin
        flag_q <= w_data_q[FLAG_BIT];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_q <= 1'b0;
    end else if (clk_en && write_go && aw_addr_q == ADDR_ENABLE_REG) begin
      irq_enable_q <= w_data_q[FLAG_BIT];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= CONTROL_RESET;
    end else if (clk_en && write_go && aw_addr_q == ADDR_CONTROL) begin
      control_q        <= w_data_q;
      control_q.unused <= 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic irq_d;
  assign irq_d = (flag_q || wrap) && irq_enable_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request          <= 1'b0;
      wake_request         <= 1'b0;
      time_base            <= '0;
      crystal_osc_power_on <= 1'b0;
      osc_pins_force_input <= 1'b0;
    end else if (clk_en) begin
      irq_request          <= irq_d;
      wake_request         <= irq_d && sleep && counter_mode && !sync_mode;
      time_base.value      <= count_q;
      time_base.valid      <= !(counter_mode && control_q.sync_bypass);
      crystal_osc_power_on <= control_q.crystal_osc_enable;
      osc_pins_force_input <= control_q.crystal_osc_enable;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channels
  // ----------------------------------------------------------------
  logic write_mapped;
  assign write_mapped = aw_addr_q == ADDR_COUNT_LOW || aw_addr_q == ADDR_COUNT_HIGH ||
                        aw_addr_q == ADDR_FLAG_REG || aw_addr_q == ADDR_ENABLE_REG ||
                        aw_addr_q == ADDR_CONTROL || aw_addr_q == ADDR_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] read_word;
  logic        read_mapped;
  always_comb begin
    read_word   = 32'h0000_0000;
    read_mapped = 1'b1;
    unique case (s_axi_araddr)
      ADDR_COUNT_LOW:  read_word[7:0] = count_q[7:0];
      ADDR_COUNT_HIGH: read_word[7:0] = count_q[15:8];
      ADDR_FLAG_REG:   read_word[FLAG_BIT] = flag_q;
      ADDR_ENABLE_REG: read_word[FLAG_BIT] = irq_enable_q;
      ADDR_CONTROL:    read_word[7:0] = control_q;
      ADDR_STATUS: begin
        read_word[STATUS_ARMED_BIT] = armed_q;
        read_word[STATUS_FORCE_BIT] = osc_pins_force_input;
        read_word[STATUS_TBASE_BIT] = time_base.valid;
      end
      default:         read_mapped = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_word;
        s_axi_rresp   <= read_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wrap_seq;
    clk_en && wrap;
  endsequence
  wrap_sets_flag_a: assert property (wrap_seq |=> flag_q && count_q == COUNT_ZERO)
    else $error("wrap did not set flag with zero count");
  // software may write the flag to one; only a hardware rise must follow a wrap
  wrap_only_max_a: assert property (clk_en && $rose(flag_q) && !$past(write_go && aw_addr_q == ADDR_FLAG_REG)
                                    |-> $past(count_q) == COUNT_MAX)
    else $error("flag rose without a wrap");
  ccp_no_flag_a: assert property (clk_en && ccp_reset && !count_write && !flag_q |=> !flag_q)
    else $error("compare reset set the flag");
  ccp_clears_a: assert property (clk_en && ccp_reset && !count_write |=> count_q == COUNT_ZERO)
    else $error("compare reset did not clear count");
  write_wins_a: assert property (clk_en && write_low |=> count_q[7:0] == $past(w_data_q))
    else $error("count write lost");
  stop_holds_a: assert property (clk_en && !control_q.count_run && !count_write && !ccp_reset
                                 |=> $stable(count_q))
    else $error("stopped count moved");
  write_clears_pre_a: assert property (clk_en && count_write |=> prescale_q == '0)
    else $error("prescaler kept its count");
  unarmed_hold_a: assert property (clk_en && counter_mode && !armed_q && !count_write && !ccp_reset
                                   |=> $stable(count_q))
    else $error("count before falling edge");
  sleep_sync_a: assert property (clk_en && sleep && sync_mode && !count_write && !ccp_reset
                                 |=> $stable(count_q))
    else $error("synchronized count moved in sleep");
  irq_mask_a: assert property (clk_en && !irq_enable_q |=> !irq_request)
    else $error("masked request raised");
  unused_zero_a: assert property (control_q.unused == 2'b00)
    else $error("unimplemented control bits set");
  tbase_async_a: assert property (clk_en && counter_mode && control_q.sync_bypass
                                  |=> !time_base.valid)
    else $error("async count offered as time base");

endmodule

// ---- sbtc_pin_source.sv ----
// Purpose: external clock source driving the timer's count pins
// Assumes: each pin level is held 3 aclk cycles, above the 2-cycle minimum
// Notes:   an idle pin rests low, so every frame opens with a rise
`timescale 1ns/100ps

module sbtc_pin_source (
  // clock
  input  wire logic aclk,
  // pins
  output logic      ext_count_pin,
  output logic      osc_input_pin
);
  initial begin
    ext_count_pin = 1'b0;
    osc_input_pin = 1'b0;
  end

  // the first fall arms the counter, so n pulses give n-1 counted rises
  task automatic pulses(input logic sel_osc, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge aclk);
      if (sel_osc) osc_input_pin <= ~osc_input_pin;
      else ext_count_pin <= ~ext_count_pin;
      repeat (2) @(posedge aclk);
    end
    // let the three-stage sampler settle before anyone reads the count
    repeat (6) @(posedge aclk);
  endtask
endmodule

// ---- sbtc_timer_bench.sv ----
// Purpose: self-checking bench for the sixteen-bit timer/counter
// Assumes: aclk at 10 MHz; one bus transfer under way at a time
// Notes:   pin traffic comes from sbtc_pin_source
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module sbtc_timer_bench
  import sbtc_pkg::*;
;
  logic aclk, aresetn, clk_en, sleep, ccp1_reset_event, ccp2_reset_event;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic irq_request, wake_request, crystal_osc_power_on, osc_pins_force_input;
  logic ext_count_pin, osc_input_pin;
  sbtc_time_base_type time_base;
  int fails, num_checks;

  sbtc_pin_source sbtc_pin_source_i (.aclk(aclk), .ext_count_pin(ext_count_pin), .osc_input_pin(osc_input_pin));

  sbtc_timer sbtc_timer_i (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .sleep(sleep),
    .ext_count_pin(ext_count_pin), .osc_input_pin(osc_input_pin),
    .ccp1_reset_event(ccp1_reset_event), .ccp2_reset_event(ccp2_reset_event),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq_request(irq_request),
    .wake_request(wake_request), .time_base(time_base),
    .crystal_osc_power_on(crystal_osc_power_on), .osc_pins_force_input(osc_pins_force_input));

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      fails++;
      $display("Error bus_wait expected answer seen timeout");
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
      if (!aw_done && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done));
    do begin
      @(posedge aclk);
      guard(n);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", rsp, s_axi_bresp)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    `CHK("rresp", rsp, s_axi_rresp)
  endtask

  task automatic chkreg(input string nm, input logic [7:0] a, input logic [7:0] ex);
    logic [31:0] d;
    rd(a, d, RESP_OKAY);
    `CHK(nm, ex, d[7:0])
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_regs;
    logic [31:0] d;
    chkreg("control_reset", ADDR_CONTROL, CONTROL_RESET);
    wr(ADDR_CONTROL, 32'h000000ff, RESP_OKAY);
    chkreg("control_upper", ADDR_CONTROL, 8'h3f);
    rd(8'h18, d, RESP_SLVERR);
    `CHK("unmapped", 32'h00000000, d)
    wr(8'h18, 32'h00000001, RESP_SLVERR);
    wr(ADDR_CONTROL, 32'h00000000, RESP_OKAY);
    $display("test regs done");
  endtask

  task automatic test_timer;
    logic [31:0] d, c;
    int n;
    n = 0;
    wr(ADDR_COUNT_LOW, 32'h000000f0, RESP_OKAY);
    wr(ADDR_COUNT_HIGH, 32'h000000ff, RESP_OKAY);
    wr(ADDR_ENABLE_REG, 32'h00000001, RESP_OKAY);
    wr(ADDR_CONTROL, 32'h00000001, RESP_OKAY);
    // a low clock enable must freeze the running count and its copy
    @(posedge aclk);
    clk_en <= 1'b0;
    repeat (2) @(posedge aclk);
    c = time_base.value;
    repeat (4) @(posedge aclk);
    `CHK("frozen", c, time_base.value)
    clk_en <= 1'b1;
    do begin
      rd(ADDR_FLAG_REG, d, RESP_OKAY);
      guard(n);
    end while (d[FLAG_BIT] !== 1'b1);
    wr(ADDR_CONTROL, 32'h00000000, RESP_OKAY);
    `CHK("irq_on", 1'b1, irq_request)
    chkreg("wrap_high", ADDR_COUNT_HIGH, 8'h00);
    rd(ADDR_COUNT_LOW, c, RESP_OKAY);
    repeat (5) @(posedge aclk);
    chkreg("held_low", ADDR_COUNT_LOW, c[7:0]);
    wr(ADDR_ENABLE_REG, 32'h00000000, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("irq_masked", 1'b0, irq_request)
    chkreg("flag_held", ADDR_FLAG_REG, 8'h01);
    wr(ADDR_FLAG_REG, 32'h00000000, RESP_OKAY);
    chkreg("flag_clear", ADDR_FLAG_REG, 8'h00);
    $display("test timer done");
  endtask

  task automatic test_counter;
    logic [1:0] ps;
    for (int p = 0; p < 4; p++) begin
      ps = 2'(p);
      wr(ADDR_CONTROL, 32'h00000000, RESP_OKAY);
      wr(ADDR_COUNT_LOW, 32'h00000000, RESP_OKAY);
      wr(ADDR_COUNT_HIGH, 32'h00000000, RESP_OKAY);
      wr(ADDR_CONTROL, {24'h0, 2'b00, ps, ps[0], 3'b011}, RESP_OKAY);
      sbtc_pin_source_i.pulses(ps[0], 17);
      chkreg("prescaled", ADDR_COUNT_LOW, 8'(16 >> p));
      `CHK("osc_force", ps[0], osc_pins_force_input)
      `CHK("osc_power", ps[0], crystal_osc_power_on)
      `CHK("base_valid", 1'b1, time_base.valid)
    end
    $display("test counter done");
  endtask

  task automatic test_sleep;
    wr(ADDR_CONTROL, 32'h00000000, RESP_OKAY);
    wr(ADDR_COUNT_LOW, 32'h00000000, RESP_OKAY);
    wr(ADDR_CONTROL, 32'h00000003, RESP_OKAY);
    @(posedge aclk);
    sleep <= 1'b1;
    sbtc_pin_source_i.pulses(1'b0, 9);
    sleep <= 1'b0;
    chkreg("sync_sleep", ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 32'h00000000, RESP_OKAY);
    wr(ADDR_COUNT_LOW, 32'h000000fe, RESP_OKAY);
    wr(ADDR_COUNT_HIGH, 32'h000000ff, RESP_OKAY);
    wr(ADDR_ENABLE_REG, 32'h00000001, RESP_OKAY);
    wr(ADDR_CONTROL, 32'h00000007, RESP_OKAY);
    @(posedge aclk);
    sleep <= 1'b1;
    sbtc_pin_source_i.pulses(1'b0, 5);
    `CHK("wake", 1'b1, wake_request)
    `CHK("base_async", 1'b0, time_base.valid)
    sleep <= 1'b0;
    chkreg("async_low", ADDR_COUNT_LOW, 8'h02);
    chkreg("async_flag", ADDR_FLAG_REG, 8'h01);
    chkreg("status", ADDR_STATUS, 8'h01);
    $display("test sleep done");
  endtask

  task automatic test_ccp;
    wr(ADDR_CONTROL, 32'h00000000, RESP_OKAY);
    wr(ADDR_FLAG_REG, 32'h00000000, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_COUNT_LOW, 32'h00000055, RESP_OKAY);
      wr(ADDR_COUNT_HIGH, 32'h00000012, RESP_OKAY);
      @(posedge aclk);
      ccp1_reset_event <= (k == 0);
      ccp2_reset_event <= (k == 1);
      @(posedge aclk);
      ccp1_reset_event <= 1'b0;
      ccp2_reset_event <= 1'b0;
      chkreg("ccp_low", ADDR_COUNT_LOW, 8'h00);
      chkreg("ccp_high", ADDR_COUNT_HIGH, 8'h00);
      `CHK("ccp_base", COUNT_ZERO, time_base.value)
    end
    chkreg("ccp_flag", ADDR_FLAG_REG, 8'h00);
    $display("test ccp done");
  endtask

  // ----------------------------------------------------------------
  // clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    {aresetn, sleep, ccp1_reset_event, ccp2_reset_event} = 4'h0;
    clk_en = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    fails = 0;
    num_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_timer();
    test_counter();
    test_sleep();
    test_ccp();
    stop_test();
  end
endmodule
